// ---- design/dofs_map.svh ----
// Constant map for the digital output function selector.
// Assumes a 200 MHz clock and a 16-bit plain register port with word indices.
`ifndef DOFS_MAP_SVH
`define DOFS_MAP_SVH

// Block shape.
`define DOFS_NUM_TERM 5
`define DOFS_SEL_W 5
`define DOFS_DATA_W 16
`define DOFS_ADDR_W 6

// Register indices on the plain port.
`define DOFS_REG_FUNC_SEL0 6'h00
`define DOFS_REG_DELAY0 6'h05
`define DOFS_REG_POLARITY 6'h0a
`define DOFS_REG_FREQ_LVL_THR 6'h0b
`define DOFS_REG_FREQ_LVL_HYST 6'h0c
`define DOFS_REG_FREQ_REACH_W 6'h0d
`define DOFS_REG_MAX_FREQ 6'h0e
`define DOFS_REG_OVL_PREWARN 6'h0f
`define DOFS_REG_SET_COUNT 6'h10
`define DOFS_REG_DESIG_COUNT 6'h11
`define DOFS_REG_SET_LENGTH 6'h12
`define DOFS_REG_RUN_TIME_THR 6'h13
`define DOFS_REG_COND_STATUS 6'h14
`define DOFS_REG_INT_STATUS 6'h15
`define DOFS_REG_INT_MASK 6'h16

// Selection codes with special handling.
`define DOFS_SEL_NONE 5'h00
`define DOFS_SEL_LAST 5'h0f

// Reset values.
`define DOFS_RST_WORD 16'h0000
`define DOFS_RST_FUNC_SEL 5'h00

// Coefficients are in units of 0.1 percent.
`define DOFS_COEFF_SCALE 32'd1000

// Times in their own units and the clock rate.
`define DOFS_CLK_KHZ 200000
`define DOFS_TICK_MS 100
`define DOFS_PLC_PULSE_MS 250
`define DOFS_OVL_LEAD_MS 16'd10000

`endif

// ---- design/dofs_pkg.sv ----
// Types shared by the digital output function selector modules.
// Assumes dofs_map.svh is on the include path.
`include "dofs_map.svh"

package dofs_pkg;

   // Status and measurements from the drive controller, same clock.
   typedef struct packed {
      logic running;
      logic fault_stop;
      logic [15:0] run_freq;
      logic [15:0] target_freq;
      logic [15:0] motor_load_pct;
      logic ovl_eta_valid;
      logic [15:0] ovl_eta_ms;
      logic counting;
      logic [15:0] count_now;
      logic fixed_length_on;
      logic [15:0] length_now;
      logic plc_cycle_done;
      logic [15:0] run_time_now;
      logic ref_beyond_limit;
      logic out_at_limit;
      logic speed_ctrl_mode;
      logic torque_at_limit;
      logic powered_on;
      logic exception_seen;
   } dofs_drive_status_type;

   // One request on the plain register port.
   typedef struct packed {
      logic [`DOFS_ADDR_W-1:0] addr;
      logic [`DOFS_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } dofs_bus_req_type;

   // Per-terminal state of the delay and polarity stage.
   typedef struct packed {
      logic [15:0] delay_cnt;
      logic active;
      logic pin;
   } dofs_term_state_type;

endpackage

// ---- design/dofs_term_stage.sv ----
// One output terminal: assertion delay in 0.1 s ticks, then polarity.
// Assumes cond and tick come from flops on the same clock.
`timescale 1ns/100ps
`include "dofs_map.svh"

module dofs_term_stage
   import dofs_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic cond,
   input wire logic tick,
   input wire logic [15:0] delay,
   input wire logic polarity,
   output logic active,
   output logic pin
);

   dofs_term_state_type st_r;
   dofs_term_state_type st_nxt;

   // The condition must hold for the whole delay; any drop restarts it.
   always_comb
   begin
      st_nxt = st_r;
      if (!cond)
      begin
         st_nxt.delay_cnt = `DOFS_RST_WORD;
         st_nxt.active = 1'b0;
      end
      else if (st_r.delay_cnt >= delay)
      begin
         st_nxt.active = 1'b1;
      end
      else if (tick)
      begin
         st_nxt.delay_cnt = st_r.delay_cnt + 16'h0001;
      end
      // Polarity 1 opens the contact while active.
      st_nxt.pin = st_nxt.active ^ polarity;
   end

   // Reset leaves the contact open whatever the polarity setting is.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign active = st_r.active;
   assign pin = st_r.pin;

endmodule // dofs_term_stage

// ---- design/dofs_selector.sv ----
// Digital output function selector: register file, condition logic, terminals.
// Assumes drive status arrives from logic on the same clock, so no synchroniser.
// How it works
// - Selection 0 keeps the terminal condition always inactive.
// - Selection 1 is active while running, even at zero frequency.
// - Selection 2 is active when the drive stopped on a fault.
// - Selection 3 sets above threshold, clears below threshold minus hysteresis.
// - Selection 4 is active within target plus or minus reach width.
// - Selection 5 is active running at zero frequency, never when stopped.
// - Selection 6 is active when motor load exceeds the pre-warning level.
// - Selection 7 is active ten seconds before drive overload protection.
// - Selection 8 is active while counting when count equals set count.
// - Selection 9 is active while counting when count equals designated count.
// - Selection 10 is active when fixed-length measurement exceeds set length.
// - Selection 11 gives one 250 ms pulse per completed program cycle.
// - Selection 12 is active once running time exceeds its threshold.
// - Selection 13 is active when reference is beyond and output at a limit.
// - Selection 14 is active at torque limit in speed control mode.
// - Selection 15 is active after power-on while no exception is seen.
// - Each terminal has a polarity bit; 1 inverts the contact.
// - Each terminal delays its active condition by a programmable time.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "dofs_map.svh"

module dofs_selector
   import dofs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `DOFS_TICK_MS * `DOFS_CLK_KHZ,
   parameter int unsigned PLC_PULSE_CYCLES = `DOFS_PLC_PULSE_MS * `DOFS_CLK_KHZ
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire dofs_bus_req_type bus_req,
   output logic [`DOFS_DATA_W-1:0] rdata,
   input wire dofs_drive_status_type drive,
   output logic [`DOFS_NUM_TERM-1:0] do_pin,
   output logic irq
);

   localparam int NT = `DOFS_NUM_TERM;

   // Whole state of the block.
   typedef struct packed {
      logic [NT-1:0][`DOFS_SEL_W-1:0] func_sel;
      logic [NT-1:0][15:0] delay;
      logic [NT-1:0] polarity;
      logic [15:0] freq_level_threshold;
      logic [15:0] freq_level_hyst_coeff;
      logic [15:0] freq_reach_width_coeff;
      logic [15:0] max_freq;
      logic [15:0] overload_prewarn_coeff;
      logic [15:0] set_count_value;
      logic [15:0] designated_count_value;
      logic [15:0] set_length_value;
      logic [15:0] run_time_threshold;
      logic frequency_level_hysteresis;
      logic [31:0] tick_cnt;
      logic tick;
      logic [31:0] pulse_cnt;
      logic pulse;
      logic [15:0] cond;
      logic [NT-1:0] term_cond;
      logic [NT-1:0] active_prev;
      logic [NT-1:0] int_status;
      logic [NT-1:0] int_mask;
      logic [`DOFS_DATA_W-1:0] rdata;
      logic irq;
   } dofs_state_type;

   dofs_state_type st_r;
   dofs_state_type st_nxt;

   logic [NT-1:0] term_active;
   logic [NT-1:0] term_pin;

   // Picks one condition by selection code; codes above the table give nothing.
   function automatic logic dofs_pick(input logic [`DOFS_SEL_W-1:0] sel, input logic [15:0] cond);
      logic hit;
      hit = 1'b0;
      if (sel == `DOFS_SEL_NONE)
      begin
         hit = 1'b0;
      end
      else if (sel <= `DOFS_SEL_LAST)
      begin
         hit = cond[sel[3:0]];
      end
      else
      begin
         hit = 1'b0;
      end
      return hit;
   endfunction

   // Scales a value by a coefficient in 0.1 percent units.
   function automatic logic [15:0] dofs_scale(input logic [15:0] value, input logic [15:0] coeff);
      logic [31:0] prod;
      prod = 32'(value) * 32'(coeff);
      return 16'(prod / `DOFS_COEFF_SCALE);
   endfunction

   // Hysteresis and reach bounds, widened by one bit so they cannot wrap.
   logic [15:0] hyst_w;
   logic [15:0] reach_w;
   logic [16:0] fdt_low;
   logic [16:0] reach_lo;
   logic [16:0] reach_hi;
   logic [16:0] run_freq_x;

   always_comb
   begin
      hyst_w = dofs_scale(st_r.freq_level_threshold, st_r.freq_level_hyst_coeff);
      reach_w = dofs_scale(st_r.max_freq, st_r.freq_reach_width_coeff);
      run_freq_x = {1'b0, drive.run_freq};
      fdt_low = {1'b0, st_r.freq_level_threshold} - {1'b0, hyst_w};
      if (fdt_low[16])
      begin
         fdt_low = 17'h00000;
      end
      reach_lo = {1'b0, drive.target_freq} - {1'b0, reach_w};
      if (reach_lo[16])
      begin
         reach_lo = 17'h00000;
      end
      reach_hi = {1'b0, drive.target_freq} + {1'b0, reach_w};
   end

   // Condition vector, timing and interrupt logic, and the register port.
   always_comb
   begin
      st_nxt = st_r;

      // A shared 0.1 s tick paces every terminal delay; one divider saves area
      // at the cost of up to one tick of jitter on each delay.
      if (st_r.tick_cnt >= TICK_CYCLES - 32'd1)
      begin
         st_nxt.tick_cnt = 32'h0000_0000;
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
         st_nxt.tick = 1'b0;
      end

      // Program cycle pulse; a new cycle end during a pulse restarts the width.
      if (drive.plc_cycle_done)
      begin
         st_nxt.pulse_cnt = PLC_PULSE_CYCLES - 32'd1;
         st_nxt.pulse = 1'b1;
      end
      else if (st_r.pulse_cnt != 32'h0000_0000)
      begin
         st_nxt.pulse_cnt = st_r.pulse_cnt - 32'h0000_0001;
      end
      else
      begin
         st_nxt.pulse = 1'b0;
      end

      // Frequency level detection holds between the two thresholds.
      if (drive.running && drive.run_freq > st_r.freq_level_threshold)
      begin
         st_nxt.frequency_level_hysteresis = 1'b1;
      end
      else if (!drive.running || run_freq_x < fdt_low)
      begin
         st_nxt.frequency_level_hysteresis = 1'b0;
      end

      // One bit for each selection code 0 to 15.
      st_nxt.cond[0] = 1'b0;
      st_nxt.cond[1] = drive.running;
      st_nxt.cond[2] = drive.fault_stop;
      st_nxt.cond[3] = st_r.frequency_level_hysteresis;
      st_nxt.cond[4] = drive.running && run_freq_x >= reach_lo && run_freq_x <= reach_hi;
      st_nxt.cond[5] = drive.running && drive.run_freq == 16'h0000;
      st_nxt.cond[6] = drive.motor_load_pct > st_r.overload_prewarn_coeff;
      st_nxt.cond[7] = drive.ovl_eta_valid && drive.ovl_eta_ms <= `DOFS_OVL_LEAD_MS;
      st_nxt.cond[8] = drive.counting && drive.count_now == st_r.set_count_value;
      st_nxt.cond[9] = drive.counting && drive.count_now == st_r.designated_count_value;
      st_nxt.cond[10] = drive.fixed_length_on && drive.length_now > st_r.set_length_value;
      st_nxt.cond[11] = st_r.pulse;
      st_nxt.cond[12] = drive.run_time_now > st_r.run_time_threshold;
      st_nxt.cond[13] = drive.ref_beyond_limit && drive.out_at_limit;
      st_nxt.cond[14] = drive.speed_ctrl_mode && drive.torque_at_limit;
      st_nxt.cond[15] = drive.powered_on && !drive.exception_seen;

      // Route the selected condition to each terminal.
      for (int i = 0; i < NT; i++)
      begin
         st_nxt.term_cond[i] = dofs_pick(st_r.func_sel[i], st_r.cond);
      end

      // Rising edge of a delayed terminal condition is the interrupt event.
      st_nxt.active_prev = term_active;

      // Register writes; write-one-to-clear yields to a same-cycle event.
      if (bus_req.wr)
      begin
         for (int i = 0; i < NT; i++)
         begin
            if (bus_req.addr == `DOFS_REG_FUNC_SEL0 + 6'(i))
            begin
               st_nxt.func_sel[i] = bus_req.wdata[`DOFS_SEL_W-1:0];
            end
            else if (bus_req.addr == `DOFS_REG_DELAY0 + 6'(i))
            begin
               st_nxt.delay[i] = bus_req.wdata;
            end
         end
         if (bus_req.addr == `DOFS_REG_POLARITY)
         begin
            st_nxt.polarity = bus_req.wdata[NT-1:0];
         end
         else if (bus_req.addr == `DOFS_REG_FREQ_LVL_THR)
         begin
            st_nxt.freq_level_threshold = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_FREQ_LVL_HYST)
         begin
            st_nxt.freq_level_hyst_coeff = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_FREQ_REACH_W)
         begin
            st_nxt.freq_reach_width_coeff = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_MAX_FREQ)
         begin
            st_nxt.max_freq = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_OVL_PREWARN)
         begin
            st_nxt.overload_prewarn_coeff = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_SET_COUNT)
         begin
            st_nxt.set_count_value = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_DESIG_COUNT)
         begin
            st_nxt.designated_count_value = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_SET_LENGTH)
         begin
            st_nxt.set_length_value = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_RUN_TIME_THR)
         begin
            st_nxt.run_time_threshold = bus_req.wdata;
         end
         else if (bus_req.addr == `DOFS_REG_INT_STATUS)
         begin
            st_nxt.int_status = st_r.int_status & ~bus_req.wdata[NT-1:0];
         end
         else if (bus_req.addr == `DOFS_REG_INT_MASK)
         begin
            st_nxt.int_mask = bus_req.wdata[NT-1:0];
         end
      end
      st_nxt.int_status = st_nxt.int_status | (term_active & ~st_r.active_prev);
      st_nxt.irq = |(st_nxt.int_status & st_nxt.int_mask);

      // Read data stand for one cycle only; unmapped indices read zero.
      st_nxt.rdata = `DOFS_RST_WORD;
      if (bus_req.rd)
      begin
         for (int i = 0; i < NT; i++)
         begin
            if (bus_req.addr == `DOFS_REG_FUNC_SEL0 + 6'(i))
            begin
               st_nxt.rdata = 16'(st_r.func_sel[i]);
            end
            else if (bus_req.addr == `DOFS_REG_DELAY0 + 6'(i))
            begin
               st_nxt.rdata = st_r.delay[i];
            end
         end
         if (bus_req.addr == `DOFS_REG_POLARITY)
         begin
            st_nxt.rdata = 16'(st_r.polarity);
         end
         else if (bus_req.addr == `DOFS_REG_FREQ_LVL_THR)
         begin
            st_nxt.rdata = st_r.freq_level_threshold;
         end
         else if (bus_req.addr == `DOFS_REG_FREQ_LVL_HYST)
         begin
            st_nxt.rdata = st_r.freq_level_hyst_coeff;
         end
         else if (bus_req.addr == `DOFS_REG_FREQ_REACH_W)
         begin
            st_nxt.rdata = st_r.freq_reach_width_coeff;
         end
         else if (bus_req.addr == `DOFS_REG_MAX_FREQ)
         begin
            st_nxt.rdata = st_r.max_freq;
         end
         else if (bus_req.addr == `DOFS_REG_OVL_PREWARN)
         begin
            st_nxt.rdata = st_r.overload_prewarn_coeff;
         end
         else if (bus_req.addr == `DOFS_REG_SET_COUNT)
         begin
            st_nxt.rdata = st_r.set_count_value;
         end
         else if (bus_req.addr == `DOFS_REG_DESIG_COUNT)
         begin
            st_nxt.rdata = st_r.designated_count_value;
         end
         else if (bus_req.addr == `DOFS_REG_SET_LENGTH)
         begin
            st_nxt.rdata = st_r.set_length_value;
         end
         else if (bus_req.addr == `DOFS_REG_RUN_TIME_THR)
         begin
            st_nxt.rdata = st_r.run_time_threshold;
         end
         else if (bus_req.addr == `DOFS_REG_COND_STATUS)
         begin
            st_nxt.rdata = 16'(term_active);
         end
         else if (bus_req.addr == `DOFS_REG_INT_STATUS)
         begin
            st_nxt.rdata = 16'(st_r.int_status);
         end
         else if (bus_req.addr == `DOFS_REG_INT_MASK)
         begin
            st_nxt.rdata = 16'(st_r.int_mask);
         end
      end
   end

   // Every setting resets to zero, so all terminals start with no function.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // One delay and polarity stage per terminal.
   generate
      for (genvar g = 0; g < NT; g++)
      begin : g_term
         dofs_term_stage u_term (
            .clock(clock),
            .resetn(resetn),
            .cond(st_r.term_cond[g]),
            .tick(st_r.tick),
            .delay(st_r.delay[g]),
            .polarity(st_r.polarity[g]),
            .active(term_active[g]),
            .pin(term_pin[g])
         );
      end
   endgenerate

   assign do_pin = term_pin;
   assign rdata = st_r.rdata;
   assign irq = st_r.irq;

endmodule // dofs_selector

// ---- verif/dofs_selector_asserts.sv ----
// Checker for the output function selector, watching only its top-level ports.
// Assumes terminal 0 carries the checked setups; a write shadow tracks its configuration.
`timescale 1ns/100ps

module dofs_selector_asserts
   import dofs_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire dofs_bus_req_type bus_req,
   input wire logic [15:0] rdata,
   input wire dofs_drive_status_type drive,
   input wire logic [4:0] do_pin,
   input wire logic irq
);
   logic [4:0] sel_r;
   logic pol_r;
   logic dly_zero_r;
   logic [3:0] quiet_r;
   logic ok;
   logic zero_speed;
   logic ready;

   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   // Shadow terminal 0 setup; quiet waits out the pipeline so past inputs and setup match.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sel_r <= 5'h00;
         pol_r <= 1'b0;
         dly_zero_r <= 1'b1;
         quiet_r <= 4'h0;
      end
      else
      begin
         if (bus_req.wr && bus_req.addr == 6'h00)
            sel_r <= bus_req.wdata[4:0];
         if (bus_req.wr && bus_req.addr == 6'h05)
            dly_zero_r <= (bus_req.wdata == 16'h0000);
         if (bus_req.wr && bus_req.addr == 6'h0a)
            pol_r <= bus_req.wdata[0];
         if (bus_req.wr && (bus_req.addr == 6'h00 || bus_req.addr == 6'h05 || bus_req.addr == 6'h0a))
            quiet_r <= 4'h0;
         else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
      end
   end

   // Settled, positive logic, no delay: the pin then mirrors the condition three cycles late.
   assign ok = quiet_r >= 4'h8 && !pol_r && dly_zero_r;
   assign zero_speed = drive.running && drive.run_freq == 16'h0000;
   assign ready = drive.powered_on && !drive.exception_seen;

   property p_rdata_idle;
      !$past(bus_req.rd) |-> rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside answer cycle");

   property p_rd_unmapped;
      $past(bus_req.rd) && $past(bus_req.addr) > 6'h16 |-> rdata == 16'h0000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read returned data");

   property p_sel_none;
      ok && sel_r == 5'h00 |-> !do_pin[0];
   endproperty
   a_sel_none: assert property (p_sel_none) else $error("terminal active with no function");

   property p_running;
      ok && sel_r == 5'h01 |-> do_pin[0] == $past(drive.running, 3);
   endproperty
   a_running: assert property (p_running) else $error("running output mismatch");

   property p_fault;
      ok && sel_r == 5'h02 |-> do_pin[0] == $past(drive.fault_stop, 3);
   endproperty
   a_fault: assert property (p_fault) else $error("fault output mismatch");

   property p_zero_speed;
      ok && sel_r == 5'h05 |-> do_pin[0] == $past(zero_speed, 3);
   endproperty
   a_zero_speed: assert property (p_zero_speed) else $error("zero speed output mismatch");

   property p_ready;
      ok && sel_r == 5'h0f |-> do_pin[0] == $past(ready, 3);
   endproperty
   a_ready: assert property (p_ready) else $error("ready output mismatch");

   property p_polarity;
      quiet_r >= 4'h8 && pol_r && sel_r == 5'h01 && (dly_zero_r || !$past(drive.running, 3))
         |-> do_pin[0] == !$past(drive.running, 3);
   endproperty
   a_polarity: assert property (p_polarity) else $error("inverted output mismatch");

   property p_unimpl;
      ok && sel_r[4] |-> !do_pin[0];
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented code drove terminal");
endmodule // dofs_selector_asserts

bind dofs_selector dofs_selector_asserts dofs_selector_asserts_i (.clock(clock), .resetn(resetn),
   .bus_req(bus_req), .rdata(rdata), .drive(drive), .do_pin(do_pin), .irq(irq));

// ---- verif/dofs_drive_model.sv ----
// Model of the drive controller status logic feeding the selector.
// Assumes the bench sets the wanted status; the model presents it from flops.
`timescale 1ns/100ps

module dofs_drive_model
   import dofs_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire dofs_drive_status_type cmd,
   output dofs_drive_status_type drive
);
   logic plc_req_r;

   // Registered like the real controller; the cycle-done flag becomes one pulse per request.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         drive <= '0;
         plc_req_r <= 1'b0;
      end
      else
      begin
         drive <= cmd;
         drive.plc_cycle_done <= cmd.plc_cycle_done && !plc_req_r;
         plc_req_r <= cmd.plc_cycle_done;
      end
   end
endmodule // dofs_drive_model

// ---- verif/dofs_selector_tb_top.sv ----
// Self-checking bench for the output function selector.
// Assumes short tick and pulse parameters so delays finish in a few cycles.
`timescale 1ns/100ps
`include "dofs_map.svh"

module dofs_selector_tb_top
   import dofs_pkg::*;
();
   logic clock;
   logic resetn;
   dofs_bus_req_type req;
   logic [15:0] rdata;
   dofs_drive_status_type cmd;
   dofs_drive_status_type drive;
   logic [4:0] do_pin;
   logic irq;
   int mismatches;
   int tests_run;
   localparam logic [15:0] HYST_F [6] = '{16'd1000, 16'd1001, 16'd950, 16'd900, 16'd899, 16'd950};
   localparam logic [5:0] HYST_E = 6'b001110;

   dofs_selector #(.TICK_CYCLES(4), .PLC_PULSE_CYCLES(10)) dofs_selector_i (.clock(clock), .resetn(resetn),
      .bus_req(req), .rdata(rdata), .drive(drive), .do_pin(do_pin), .irq(irq));
   dofs_drive_model dofs_drive_model_i (.clock(clock), .resetn(resetn), .cmd(cmd), .drive(drive));

   // Half period of 2.5 ns gives 200 MHz.
   always #2.5 clock = ~clock;

   task check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clock);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clock);
      req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge clock);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clock);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task put(input dofs_drive_status_type v);
      @(posedge clock);
      cmd <= v;
   endtask

   task settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   function automatic dofs_drive_status_type mk(input logic [4:0] c, input logic on);
      dofs_drive_status_type s;
      s = '0;
      s.target_freq = 16'd500;
      s.counting = 1'b1;
      s.fixed_length_on = 1'b1;
      s.ovl_eta_valid = 1'b1;
      s.ref_beyond_limit = 1'b1;
      s.torque_at_limit = 1'b1;
      s.powered_on = 1'b1;
      case (c)
         5'h01: s.running = on;
         5'h02: s.fault_stop = on;
         5'h04: {s.running, s.run_freq} = {1'b1, on ? 16'd600 : 16'd601};
         5'h05: {s.running, s.run_freq} = {on, 16'd0};
         5'h06: s.motor_load_pct = on ? 16'd501 : 16'd500;
         5'h07: s.ovl_eta_ms = on ? 16'd10000 : 16'd10001;
         5'h08: s.count_now = on ? 16'd50 : 16'd51;
         5'h09: s.count_now = on ? 16'd70 : 16'd71;
         5'h0a: s.length_now = on ? 16'd301 : 16'd300;
         5'h0c: s.run_time_now = on ? 16'd1001 : 16'd1000;
         5'h0d: s.out_at_limit = on;
         5'h0e: s.speed_ctrl_mode = on;
         5'h0f: s.exception_seen = !on;
         default: s = '1;
      endcase
      return s;
   endfunction

   task t_regs;
      logic [15:0] v;
      for (int a = 0; a < 24; a++)
      begin
         rd(6'(a), v);
         check(v, 16'h0000);
      end
      wr(`DOFS_REG_COND_STATUS, 16'h001f);
      rd(`DOFS_REG_COND_STATUS, v);
      check(v, 16'h0000);
      wr(`DOFS_REG_FUNC_SEL0, 16'hffff);
      rd(`DOFS_REG_FUNC_SEL0, v);
      check(v, 16'h001f);
      rd(6'h3f, v);
      check(v, 16'h0000);
      wr(`DOFS_REG_FUNC_SEL0, 16'h0000);
      $display("test registers done");
   endtask

   // Codes 0 to 16 except 3 and 11 on all terminals; codes 1 to 15 just past and just short of their boundary.
   task t_codes;
      logic [15:0] e;
      wr(`DOFS_REG_MAX_FREQ, 16'd1000);
      wr(`DOFS_REG_FREQ_REACH_W, 16'd100);
      wr(`DOFS_REG_OVL_PREWARN, 16'd500);
      wr(`DOFS_REG_SET_COUNT, 16'd50);
      wr(`DOFS_REG_DESIG_COUNT, 16'd70);
      wr(`DOFS_REG_SET_LENGTH, 16'd300);
      wr(`DOFS_REG_RUN_TIME_THR, 16'd1000);
      for (int c = 0; c < 17; c++)
      begin
         if (c == 3 || c == 11)
            continue;
         for (int t = 0; t < 5; t++)
            wr(6'(t), 16'(c));
         for (int on = 1; on >= 0; on--)
         begin
            put(mk(5'(c), 1'(on)));
            settle(8);
            e = (on == 1 && c > 0 && c < 16) ? 16'h001f : 16'h0000;
            if (c < 8)
               check({11'h0, do_pin}, e);
            else
               check({11'h0, do_pin}, e);
         end
      end
      $display("test codes done");
   endtask

   // Threshold 1000 and 10 percent hysteresis: set above 1000, clear only below 900.
   task t_hyst;
      dofs_drive_status_type s;
      wr(`DOFS_REG_FUNC_SEL0, 16'd3);
      wr(`DOFS_REG_FREQ_LVL_THR, 16'd1000);
      wr(`DOFS_REG_FREQ_LVL_HYST, 16'd100);
      s = '0;
      s.running = 1'b1;
      put(s);
      for (int i = 0; i < 6; i++)
      begin
         s.run_freq = HYST_F[i];
         put(s);
         settle(8);
         check({15'h0, do_pin[0]}, {15'h0, HYST_E[i]});
      end
      $display("test hysteresis done");
   endtask

   task t_pulse;
      dofs_drive_status_type s;
      int n;
      wr(`DOFS_REG_FUNC_SEL0, 16'd11);
      s = '0;
      s.plc_cycle_done = 1'b1;
      put(s);
      put('0);
      n = 0;
      repeat (40)
      begin
         @(posedge clock);
         #1;
         if (do_pin[0] === 1'b1)
            n++;
      end
      check(16'(n), 16'd10);
      $display("test pulse done");
   endtask

   // Inverted terminal with three ticks of delay, then interrupt raise, clear and mask.
   task t_delay_irq;
      logic [15:0] v;
      wr(`DOFS_REG_INT_STATUS, 16'h001f);
      wr(`DOFS_REG_FUNC_SEL0, 16'd1);
      wr(`DOFS_REG_DELAY0, 16'd3);
      wr(`DOFS_REG_POLARITY, 16'h0001);
      wr(`DOFS_REG_INT_MASK, 16'h0001);
      put(mk(5'h01, 1'b1));
      settle(6);
      check({15'h0, do_pin[0]}, 16'h0001);
      check({15'h0, irq}, 16'h0000);
      settle(24);
      check({15'h0, do_pin[0]}, 16'h0000);
      check({15'h0, irq}, 16'h0001);
      rd(`DOFS_REG_INT_STATUS, v);
      check(v, 16'h0001);
      rd(`DOFS_REG_COND_STATUS, v);
      check(v, 16'h0001);
      wr(`DOFS_REG_INT_STATUS, 16'h0001);
      settle(2);
      check({15'h0, irq}, 16'h0000);
      wr(`DOFS_REG_INT_MASK, 16'h0000);
      put(mk(5'h01, 1'b0));
      settle(4);
      put(mk(5'h01, 1'b1));
      settle(30);
      check({15'h0, irq}, 16'h0000);
      rd(`DOFS_REG_INT_STATUS, v);
      check(v, 16'h0001);
      $display("test delay and interrupt done");
   endtask

   task finish_test;
      $display("Counts: %0d mismatches in %0d comparisons", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Main sequence: five cycles of reset, then each scenario in turn.
   initial
   begin
      clock = 1'b0;
      resetn = 1'b0;
      req = '0;
      cmd = '0;
      mismatches = 0;
      tests_run = 0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      t_regs;
      t_codes;
      t_hyst;
      t_pulse;
      t_delay_irq;
      finish_test;
   end

   // The scenarios need well under 5000 cycles, so this only fires on a hang.
   initial
   begin
      repeat (20000) @(posedge clock);
      mismatches++;
      finish_test;
   end
endmodule // dofs_selector_tb_top
